// ### common/cief_map.vh
// Register offsets, field positions, reset values and timing counts
`ifndef CIEF_MAP_VH
`define CIEF_MAP_VH
`define CIEF_ADDR_FLAG1      8'h88
`define CIEF_ADDR_EN_C       8'h9a
`define CIEF_ADDR_EN_B       8'hb8
`define CIEF_ADDR_EN_A       8'ha8
`define CIEF_GLB_EN_BIT      7
`define CIEF_RST_FLAG1       8'h05
`define CIEF_RST_EN          8'h00
`define CIEF_FLAG1_WMASK     8'haa
`define CIEF_VEC_BASE        8'h03
`define CIEF_VEC_STEP        8'h08
`define CIEF_NSRC            18
`define CIEF_DETECT_CYC      3'h1
`define CIEF_CALL_CYC        3'h6
`define CIEF_LAT_CYC         (`CIEF_DETECT_CYC + `CIEF_CALL_CYC)
`endif

// ### logic/cief_arbiter.v
// Priority arbiter picking the lowest-numbered highest-priority request
`timescale 1ns/1ps
module cief_arbiter #(
    parameter NSRC = 18
) (
    input  wire [NSRC-1:0]   req,
    input  wire [2*NSRC-1:0] prio,
    output reg               found,
    output reg  [4:0]        winner,
    output reg  [1:0]        winPrio
);
    integer i;
    always @* begin
        found   = 1'b0;
        winner  = 5'h00;
        winPrio = 2'h0;
        for (i = NSRC - 1; i >= 0; i = i - 1) begin
            if (req[i] && (!found || prio[2*i +: 2] >= winPrio)) begin
                found   = 1'b1;
                winner  = i[4:0];
                winPrio = prio[2*i +: 2];
            end
        end
    end
endmodule // cief_arbiter

// ### logic/cief_irq_ctrl.v
// Interrupt enable, flag and vectoring logic
// Summary of operation
// - Enable group B: port0, timers four..one, DMA; all reset to zero.
// - Enable group C: watchdog, port1, serial tx pair, port2/USB, radio.
// - Event sets CPU flag whether enabled or not.
// - Enabled pending source gets long call to its vector.
// - Vectors at 0x03 plus eight bytes per interrupt number.
// - Only strictly higher priority preempts a running service.
// - Return from service outside the detect and call states ends it and resumes prior flow.
// - Minimum latency seven cycles: one detect plus six for call.
// - Radio, ADC and serial rx flags (sources 0..3) clear on vectoring; timer flags do not.
// - Clearing a module flag re-asserts CPU flag of enabled sources 0..3 if others remain.
// - Flag group one: bits 7,5,3,1 hold pending flags, reset zero.
// - Flag group one bits 2 and 0 reserved, held at one.
// - Peripheral CPU flag needs at least one peripheral mask bit set.
// - Nothing taken unless global enable bit is one.
`timescale 1ns/1ps
`include "cief_map.vh"
module cief_irq_ctrl #(
    parameter NSRC = 18
) (
    input  wire              clk,
    input  wire              reset,
    input  wire              sfrWrite,
    input  wire [7:0]        sfrAddr,
    input  wire [7:0]        sfrWdata,
    output reg  [7:0]        sfrRdata_q,
    input  wire [NSRC-1:0]   srcEvent,
    input  wire [NSRC-1:0]   srcMaskAny,
    input  wire [NSRC-1:0]   moduleFlagClr,
    input  wire [NSRC-1:0]   modulePending,
    input  wire [NSRC-1:0]   extFlag,
    input  wire [2*NSRC-1:0] srcPrio,
    input  wire              returnFromService,
    output reg               longCall_q,
    output reg  [7:0]        vectorAddr_q,
    output reg  [NSRC-1:0]   vectorAck_q,
    output reg               inService_q
);
    reg [7:0]      flag1_q;
    reg [7:0]      enB_q;
    reg [7:0]      enC_q;
    reg [7:0]      enA_q;
    reg [1:0]      state_q;
    reg [2:0]      cnt_q;
    reg [4:0]      pickNum_q;
    reg [1:0]      depth_q;
    reg [1:0]      prioStk0_q;
    reg [1:0]      prioStk1_q;
    reg [1:0]      curPrio_q;
    reg [NSRC-1:0] cpuFlag;
    reg [NSRC-1:0] srcEn;
    reg [NSRC-1:0] rearm;
    reg [NSRC-1:0] hwClr;
    wire           found;
    wire [4:0]     winner;
    wire [1:0]     winPrio;
    wire           anyClr = |moduleFlagClr;

    localparam [1:0] ST_IDLE   = 2'h0;
    localparam [1:0] ST_DETECT = 2'h1;
    localparam [1:0] ST_CALL   = 2'h2;

    function [7:0] vecOf;
        input [4:0] num;
        begin
            vecOf = `CIEF_VEC_BASE + {num[4:0], 3'h0};
        end
    endfunction

    always @* begin
        srcEn = {NSRC{1'b0}};
        srcEn[8]  = enB_q[0];
        srcEn[9]  = enB_q[1];
        srcEn[10] = enB_q[2];
        srcEn[11] = enB_q[3];
        srcEn[12] = enB_q[4];
        srcEn[13] = enB_q[5];
        srcEn[0]  = enA_q[0];
        srcEn[1]  = enA_q[1];
        srcEn[2]  = enA_q[2];
        srcEn[3]  = enA_q[3];
        srcEn[4]  = enA_q[4];
        srcEn[5]  = enA_q[5];
        srcEn[16] = enC_q[0];
        srcEn[6]  = enC_q[1];
        srcEn[7]  = enC_q[2];
        srcEn[14] = enC_q[3];
        srcEn[15] = enC_q[4];
        srcEn[17] = enC_q[5];
        cpuFlag = extFlag;
        cpuFlag[0] = flag1_q[1];
        cpuFlag[1] = flag1_q[5];
        cpuFlag[2] = flag1_q[3];
        cpuFlag[3] = flag1_q[7];
        rearm = anyClr ? (modulePending & ~moduleFlagClr & srcEn)
                       : {NSRC{1'b0}};
    end

    cief_arbiter #(
        .NSRC (NSRC)
    ) u_arb (
        .req     (cpuFlag & srcEn & {NSRC{enA_q[`CIEF_GLB_EN_BIT]}}),
        .prio    (srcPrio),
        .found   (found),
        .winner  (winner),
        .winPrio (winPrio)
    );

    wire canTake = found && (depth_q == 2'h0 || winPrio > curPrio_q)
                   && depth_q != 2'h2
                   && !(returnFromService && depth_q != 2'h0);

    always @* begin
        hwClr = {NSRC{1'b0}};
        if (longCall_q && pickNum_q <= 5'd3)
            hwClr[pickNum_q] = 1'b1;
    end

    always @(posedge clk) begin
        if (reset) begin
            flag1_q      <= `CIEF_RST_FLAG1;
            enB_q        <= `CIEF_RST_EN;
            enC_q        <= `CIEF_RST_EN;
            enA_q        <= `CIEF_RST_EN;
            state_q      <= ST_IDLE;
            cnt_q        <= 3'h0;
            pickNum_q    <= 5'h00;
            depth_q      <= 2'h0;
            prioStk0_q   <= 2'h0;
            prioStk1_q   <= 2'h0;
            curPrio_q    <= 2'h0;
            longCall_q   <= 1'b0;
            vectorAddr_q <= 8'h00;
            vectorAck_q  <= {NSRC{1'b0}};
            inService_q  <= 1'b0;
            sfrRdata_q   <= 8'h00;
        end else begin
            longCall_q  <= 1'b0;
            vectorAck_q <= {NSRC{1'b0}};
            if (sfrWrite) begin
                case (sfrAddr)
                    `CIEF_ADDR_FLAG1: flag1_q <= (sfrWdata
                        & `CIEF_FLAG1_WMASK) | `CIEF_RST_FLAG1;
                    `CIEF_ADDR_EN_B: enB_q <= {2'h0, sfrWdata[5:0]};
                    `CIEF_ADDR_EN_C: enC_q <= {2'h0, sfrWdata[5:0]};
                    `CIEF_ADDR_EN_A: enA_q <= {sfrWdata[7], 1'b0,
                                               sfrWdata[5:0]};
                    default: ;
                endcase
            end
            // event set regardless of enable, peripheral mask needed; re-arm set needs enable
            // Set wins over clear
            if (hwClr[3]) flag1_q[7] <= 1'b0;
            if (hwClr[1]) flag1_q[5] <= 1'b0;
            if (hwClr[2]) flag1_q[3] <= 1'b0;
            if (hwClr[0]) flag1_q[1] <= 1'b0;
            if ((srcEvent[3] && srcMaskAny[3]) || rearm[3])
                flag1_q[7] <= 1'b1;
            if ((srcEvent[1] && srcMaskAny[1]) || rearm[1])
                flag1_q[5] <= 1'b1;
            if ((srcEvent[2] && srcMaskAny[2]) || rearm[2])
                flag1_q[3] <= 1'b1;
            if ((srcEvent[0] && srcMaskAny[0]) || rearm[0])
                flag1_q[1] <= 1'b1;
            flag1_q[2] <= 1'b1;
            flag1_q[0] <= 1'b1;
            case (sfrAddr)
                `CIEF_ADDR_FLAG1: sfrRdata_q <= flag1_q;
                `CIEF_ADDR_EN_B:  sfrRdata_q <= enB_q;
                `CIEF_ADDR_EN_C:  sfrRdata_q <= enC_q;
                `CIEF_ADDR_EN_A:  sfrRdata_q <= enA_q;
                default:          sfrRdata_q <= 8'h00;
            endcase
            case (state_q)
                ST_IDLE: begin
                    if (canTake) begin
                        state_q   <= ST_DETECT;
                        pickNum_q <= winner;
                        prioStk1_q <= prioStk0_q;
                        prioStk0_q <= curPrio_q;
                        curPrio_q <= winPrio;
                    end
                end
                ST_DETECT: begin
                    state_q <= ST_CALL;
                    cnt_q   <= 3'h1;
                end
                ST_CALL: begin
                    cnt_q <= cnt_q + 3'h1;
                    if (cnt_q == `CIEF_CALL_CYC) begin
                        state_q      <= ST_IDLE;
                        longCall_q   <= 1'b1;
                        vectorAddr_q <= vecOf(pickNum_q);
                        vectorAck_q  <= {{(NSRC-1){1'b0}}, 1'b1}
                                        << pickNum_q;
                        depth_q      <= depth_q + 2'h1;
                        inService_q  <= 1'b1;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
            if (returnFromService && depth_q != 2'h0
                    && state_q == ST_IDLE) begin
                depth_q     <= depth_q - 2'h1;
                curPrio_q   <= prioStk0_q;
                prioStk0_q  <= prioStk1_q;
                inService_q <= depth_q != 2'h1;
            end
        end
    end
endmodule // cief_irq_ctrl

// ### tb/cief_irq_ctrl_chk.sv
// Port checks for the interrupt controller
`timescale 1ns/1ps
module cief_irq_ctrl_chk #(
    parameter NSRC = 18
) (
    input wire            clk,
    input wire            reset,
    input wire            sfrWrite,
    input wire [7:0]      sfrAddr,
    input wire [7:0]      sfrWdata,
    input wire [7:0]      sfrRdata_q,
    input wire            longCall_q,
    input wire [7:0]      vectorAddr_q,
    input wire [NSRC-1:0] vectorAck_q,
    input wire            inService_q
);
    logic       glbEn_q;
    logic [7:0] expVec;
    always_ff @(posedge clk) begin
        if (reset)
            glbEn_q <= 1'b0;
        else if (sfrWrite && sfrAddr == 8'ha8)
            glbEn_q <= sfrWdata[7];
    end
    always_comb begin
        expVec = 8'h00;
        for (int i = 0; i < NSRC; i++)
            if (vectorAck_q[i])
                expVec = 8'h03 + 8'(8 * i);
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_call_spacing: assert property (
        longCall_q |=> !longCall_q [*7]) else $error("call spacing");
    a_ack_onehot: assert property (
        longCall_q |-> $onehot(vectorAck_q)) else $error("ack not onehot");
    a_ack_alone: assert property (
        vectorAck_q != '0 |-> longCall_q) else $error("ack without call");
    a_vector_map: assert property (
        longCall_q |-> vectorAddr_q == expVec) else $error("bad vector");
    a_vector_hold: assert property (
        !longCall_q |-> $stable(vectorAddr_q)) else $error("vector moved");
    a_service_set: assert property (
        longCall_q |-> inService_q) else $error("not in service");
    a_global_gate: assert property (
        longCall_q |-> $past(glbEn_q, 8))
        else $error("call with global enable low");
    a_flag_fixed: assert property (
        !$past(reset) && $past(sfrAddr) == 8'h88
        |-> sfrRdata_q[2] && sfrRdata_q[0]) else $error("reserved bit low");
    a_unmapped_zero: assert property (
        !$past(reset) && !($past(sfrAddr) inside
        {8'h88, 8'h9a, 8'hb8, 8'ha8}) |-> sfrRdata_q == 8'h00)
        else $error("unmapped read");
endmodule // cief_irq_ctrl_chk
bind cief_irq_ctrl cief_irq_ctrl_chk #(.NSRC(NSRC)) chk (.clk(clk),
    .reset(reset), .sfrWrite(sfrWrite), .sfrAddr(sfrAddr),
    .sfrWdata(sfrWdata), .sfrRdata_q(sfrRdata_q), .longCall_q(longCall_q),
    .vectorAddr_q(vectorAddr_q), .vectorAck_q(vectorAck_q),
    .inService_q(inService_q));

// ### tb/cief_cpu_model.sv
// Behavioural CPU core returning from service routines
`timescale 1ns/1ps
module cief_cpu_model (
    input  wire  clk,
    input  wire  reset,
    input  wire  longCall_q,
    input  wire  autoRet,
    input  wire  retReq,
    output logic returnFromService
);
    logic [2:0] svcCnt_q;
    always_ff @(posedge clk) begin
        if (reset)
            svcCnt_q <= 3'h0;
        else if (longCall_q)
            svcCnt_q <= 3'h4;
        else if (svcCnt_q != 3'h0)
            svcCnt_q <= svcCnt_q - 3'h1;
    end
    assign returnFromService = retReq | (autoRet & (svcCnt_q == 3'h1));
endmodule // cief_cpu_model

// ### tb/cief_irq_ctrl_test.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
`include "cief_map.vh"
module cief_irq_ctrl_test;
    logic        clk = 0, reset = 1, sfrWrite = 0, autoRet = 1, retReq = 0;
    logic [7:0]  sfrAddr = 0, sfrWdata = 0;
    logic [17:0] srcEvent = 0, srcMaskAny = '1, modClr = 0, modPend = 0;
    logic [17:0] extFlag = 0;
    logic [35:0] srcPrio = 0;
    wire  [7:0]  rdat, vec;
    wire  [17:0] ack;
    wire         call, inSvc, ret;
    int          fail_count = 0, check_count = 0, n;
    logic [15:0] en;
    localparam logic [223:0] EN_MAP = {16'h9a20, 16'h9a01, 16'h9a10,
        16'h9a08, 16'hb820, 16'hb810, 16'hb808, 16'hb804, 16'hb802,
        16'hb801, 16'h9a04, 16'h9a02, 16'ha8a0, 16'ha890};
    always #12.5 clk = ~clk;
    cief_irq_ctrl #(.NSRC(18)) uut (.clk(clk), .reset(reset),
        .sfrWrite(sfrWrite), .sfrAddr(sfrAddr), .sfrWdata(sfrWdata),
        .sfrRdata_q(rdat), .srcEvent(srcEvent), .srcMaskAny(srcMaskAny),
        .moduleFlagClr(modClr), .modulePending(modPend), .extFlag(extFlag),
        .srcPrio(srcPrio), .returnFromService(ret), .longCall_q(call),
        .vectorAddr_q(vec), .vectorAck_q(ack), .inService_q(inSvc));
    cief_cpu_model cpu (.clk(clk), .reset(reset), .longCall_q(call),
        .autoRet(autoRet), .retReq(retReq), .returnFromService(ret));
    task tick; @(posedge clk); #1; endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input string what, input logic [17:0] e, input logic [17:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        sfrAddr = a; sfrWdata = d; sfrWrite = 1; tick; sfrWrite = 0; tick;
    endtask
    task rd(input [7:0] a, input [7:0] e);
        sfrAddr = a; tick; chk("rdata", e, rdat);
    endtask
    task ev(input [17:0] m); srcEvent = m; tick; srcEvent = 0; endtask
    task rti; retReq = 1; tick; retReq = 0; endtask
    task noCall(input int k);
        repeat (k) begin tick; chk("call", 0, call); end
    endtask
    task waitCall(input [7:0] v, input int s);
        n = 0;
        do begin tick; n++; end while (call !== 1'b1 && n < 40);
        if (call !== 1'b1) begin
            chk("call", 1, call);
            print_verdict;
        end
        else begin chk("vector", v, vec); chk("ack", 18'h1 << s, ack); end
    endtask
    task t_regs;
        rd(8'h88, 8'h05);
        rd(8'h42, 8'h00);
        wr(8'hb8, 8'h3f); rd(8'hb8, 8'h3f);
        wr(8'h9a, 8'h3f); rd(8'h9a, 8'h3f);
        wr(8'hb8, 8'h00); wr(8'h9a, 8'h00);
        $display("t_regs done");
    endtask
    task t_flags;
        ev(18'hf); rd(8'h88, 8'haf);
        wr(8'ha8, 8'h0f); noCall(12); wr(8'ha8, 8'h00);
        wr(8'h88, 8'h05); rd(8'h88, 8'h05);
        srcMaskAny[1] = 0; ev(18'h2); rd(8'h88, 8'h05);
        srcMaskAny = '1;
        $display("t_flags done");
    endtask
    task t_tie;
        autoRet = 0; wr(8'ha8, 8'h89); ev(18'h9);
        waitCall(8'h03, 0);
        chk("service", 1, inSvc);
        tick; rd(8'h88, 8'h85);
        rti; waitCall(8'h1b, 3);
        tick; rd(8'h88, 8'h05);
        rti; chk("service", 0, inSvc);
        wr(8'ha8, 8'h00);
        $display("t_tie done");
    endtask
    task t_nest;
        srcPrio[5:4] = 2'h1; wr(8'ha8, 8'h87); ev(18'h2);
        waitCall(8'h0b, 1);
        ev(18'h5); waitCall(8'h13, 2);
        noCall(20); rti; chk("service", 1, inSvc);
        noCall(20);
        rti; waitCall(8'h03, 0);
        rti; wr(8'ha8, 8'h00); srcPrio = 0;
        $display("t_nest done");
    endtask
    task t_rearm;
        autoRet = 1; wr(8'ha8, 8'h81); modPend[0] = 1; modClr[1] = 1;
        tick; modClr = 0; waitCall(8'h03, 0);
        modPend = 0; noCall(10); wr(8'ha8, 8'h00);
        $display("t_rearm done");
    endtask
    task t_ext;
        for (int s = 4; s <= 17; s++) begin
            en = EN_MAP[16*(s-4) +: 16];
            wr(8'ha8, 8'h80); wr(en[15:8], en[7:0]);
            extFlag[s] = 1; waitCall(8'(8'h03 + 8 * s), s);
            if (s == 4) chk("latency", `CIEF_LAT_CYC + 1, n);
            // module flag already clear, then CPU flag
            extFlag[s] = 0; repeat (6) tick; wr(en[15:8], 8'h00);
        end
        $display("t_ext done");
    endtask
    initial begin
        repeat (6) @(posedge clk);
        #1 reset = 0;
        t_regs; t_flags; t_tie; t_nest; t_rearm; t_ext;
        print_verdict;
    end
endmodule // cief_irq_ctrl_test
